// file: src/sfpic_pkg.sv
/*
  Shared constants and types of the sector flash host controller.
  Assumes a 25 MHz core clock; every cycle count except SYNC_CYC derives from it.
*/
package sfpic_pkg;
  // ----------------------------------------
  // Clock and strobe timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40; // 25 MHz core clock
  localparam int T_WP_NS = 200; // Write pulse width, least
  localparam int T_WPH_NS = 200; // Write pulse high, least
  localparam int T_ACC_NS = 120; // Address to output, most
  localparam int T_OEHP_NS = 150; // Output drive high pulse, least
  localparam int T_BLC_US = 150; // byte_load_gap_limit
  localparam int T_WC_MS = 20; // program_cycle_duration
  localparam int SYNC_CYC = 2; // Two-stage data synchroniser
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OEHP_CYC = (T_OEHP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // One spare cycle covers the pin-to-first-stage sampling slack
  localparam int RD_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC + 1;
  localparam int BLC_CYC = (T_BLC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Least wait
  localparam int BLC_MAX_CYC = (T_BLC_US * 1000) / CLK_PERIOD_NS; // Longest gap
  localparam int WC_CYC = (T_WC_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Array geometry and command codes
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int SECTOR_BYTES = 128;
  localparam int SECT_LSB = 7; // Low end of sector_number_field
  localparam int UNLOCK_STEPS = 3;
  localparam int TOG_BIT = 6; // toggle_status_bit
  localparam int POLL_BIT = 7; // poll_status_bit
  localparam logic [15:0] UNL_A0 = 16'h5555;
  localparam logic [15:0] UNL_A1 = 16'h2AAA;
  localparam logic [7:0] UNL_D0 = 8'hAA;
  localparam logic [7:0] UNL_D1 = 8'h55;
  localparam logic [7:0] CMD_PGM = 8'hA0;
  localparam logic [7:0] CMD_IDIN = 8'h90;
  localparam logic [7:0] CMD_IDOUT = 8'hF0;

  // ----------------------------------------
  // Software register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SECTOR = 8'h04;
  localparam logic [7:0] REG_RADDR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] REG_IRQ_EN = 8'h18;
  localparam int BUF_SEL_BIT = 7; // Offsets 0x80..0xFF hit the byte buffer
  localparam int STAT_BUSY = 0;
  localparam int STAT_POLL_OK = 1;
  localparam int STAT_RDATA_LSB = 8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TMO = 1;
  localparam int IRQ_W = 2;

  // Operations started through the control register
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PGM = 2'b01,
    OP_IDIN = 2'b10,
    OP_IDOUT = 2'b11
  } sfpic_op_t;

  // One bus cycle towards the flash
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sfpic_req_t;

  // Flash pin group, strobes active low
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
  } sfpic_pins_t;

  localparam sfpic_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 16'h0000, 8'h00, 1'b0};
endpackage : sfpic_pkg

// file: src/sfpic_strobe.sv
/*
  Flash strobe engine: runs one write or read cycle on the parallel pins.
  Assumes one request at a time, offered only while no cycle is running.
*/
`timescale 1ns/100ps
`default_nettype none
module sfpic_strobe
  import sfpic_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid, // Start pulse
  input wire sfpic_req_t req, // Cycle to run
  input wire logic [DATA_W-1:0] dq_in, // Raw data pins
  output logic done, // One-cycle pulse at cycle end
  output logic [DATA_W-1:0] rdata, // Captured read byte
  output sfpic_pins_t pins // Pin drive, registered
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {
    SFS_IDLE = 2'b00,
    SFS_ACT = 2'b01,
    SFS_REC = 2'b10
  } sfpic_sst_t;

  sfpic_sst_t st_ff, nxt_st; // Cycle phase
  logic [3:0] cnt_ff, nxt_cnt; // Phase countdown
  logic wr_ff, nxt_wr; // Cycle is a write
  sfpic_pins_t pins_ff, nxt_pins;
  logic done_ff, nxt_done;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff; // Data synchroniser

  // Data pins come from another timing world; only stage two is read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
    end else begin
      dq_s1_ff <= dq_in;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  // Next-state of the strobe phases
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_wr = wr_ff;
    nxt_pins = pins_ff;
    nxt_done = 1'b0;
    nxt_rdata = rdata_ff;
    case (st_ff)
      SFS_IDLE: begin
        if (req_valid) begin
          nxt_wr = req.wr;
          nxt_pins.addr = req.addr;
          nxt_pins.dq = req.data;
          nxt_pins.ce_n = 1'b0;
          // Output drive stays high during writes so no read is seen
          nxt_pins.oe_n = req.wr; // see R12
          nxt_pins.we_n = ~req.wr;
          nxt_pins.dq_oe = req.wr;
          nxt_cnt = req.wr ? 4'(WP_CYC - 1) : 4'(RD_CYC - 1);
          nxt_st = SFS_ACT;
        end
      end
      SFS_ACT: begin
        if (cnt_ff == 4'h0) begin
          // Raise strobes; data stays driven through recovery for hold
          nxt_pins.ce_n = 1'b1;
          nxt_pins.oe_n = 1'b1;
          nxt_pins.we_n = 1'b1;
          if (!wr_ff) begin
            nxt_rdata = dq_s2_ff;
          end
          nxt_cnt = wr_ff ? 4'(WPH_CYC - 1) : 4'(OEHP_CYC - 1);
          nxt_st = SFS_REC;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      SFS_REC: begin
        if (cnt_ff == 4'h0) begin
          nxt_pins.dq_oe = 1'b0;
          nxt_done = 1'b1;
          nxt_st = SFS_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      default: begin
        nxt_pins = PINS_IDLE;
        nxt_st = SFS_IDLE;
      end
    endcase
  end

  // Register the phase state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= SFS_IDLE;
      cnt_ff <= 4'h0;
      wr_ff <= 1'b0;
      pins_ff <= PINS_IDLE;
      done_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      wr_ff <= nxt_wr;
      pins_ff <= nxt_pins;
      done_ff <= nxt_done;
      rdata_ff <= nxt_rdata;
    end
  end

  assign done = done_ff;
  assign rdata = rdata_ff;
  assign pins = pins_ff;
endmodule : sfpic_strobe
`default_nettype wire

// file: src/sfpic_host.sv
/*
  Host controller for a sector-programmed parallel flash: program,
  toggle polling, identification entry and exit, single reads.
  Assumes a register master on the same clock and the flash on the pins.
*/
// Notes on behaviour
// R01 - Sector number on address during each load
// R02 - Always load all 128 sector bytes
// R03 - Unloaded bytes end up undefined
// R04 - Next byte load within 150 us
// R05 - Protection re-arms after every program
// R06 - Toggle bit flips per read while busy
// R07 - Completion is two agreeing toggle reads
// R08 - Keep polling address constant
// R09 - Identity select picks maker or part code
// R10 - Identification mode lost at power-down
// R11 - Exit sequence returns to array read
// R12 - Output drive high during write strobes
// R13 - Program cycle ends within 20 ms
// R14 - Poll bit inverted until cycle ends
`timescale 1ns/100ps
`default_nettype none
module sfpic_host
  import sfpic_pkg::*;
#(
  parameter int TMO_CYC = WC_CYC // Polling timeout, cycles
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic IRQ,
  output logic FLASH_CE_N,
  output logic FLASH_OE_N,
  output logic FLASH_WE_N,
  output logic [ADDR_W-1:0] FLASH_ADDR,
  output logic [DATA_W-1:0] FLASH_DQ_OUT,
  output logic FLASH_DQ_OE,
  input wire logic [DATA_W-1:0] FLASH_DQ_IN
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  typedef enum logic [2:0] {
    SFH_IDLE = 3'b000,
    SFH_WR = 3'b001,
    SFH_RD = 3'b010,
    SFH_GAP = 3'b011,
    SFH_POLL = 3'b100
  } sfpic_hst_t;

  sfpic_hst_t state_ff, nxt_state; // Sequencer state
  sfpic_op_t op_ff, nxt_op; // Running operation
  logic [7:0] step_ff, nxt_step; // Write index in the sequence
  logic issued_ff, nxt_issued; // A bus cycle is in flight
  logic [19:0] tmo_ff, nxt_tmo; // Gap and timeout counter
  logic tog_prev_ff, nxt_tog_prev; // Toggle bit of last poll read
  logic have_prev_ff, nxt_have_prev;
  logic poll_ok_ff, nxt_poll_ok; // Poll bit matched last byte
  logic [DATA_W-1:0] rdata_last_ff, nxt_rdata_last;
  logic [8:0] sector_ff, nxt_sector; // Target sector
  logic [ADDR_W-1:0] raddr_ff, nxt_raddr; // Single-read address
  logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [IRQ_W-1:0] irq_en_ff, nxt_irq_en;
  logic irq_ff, nxt_irq;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [DATA_W-1:0] buf_mem [SECTOR_BYTES]; // Staged sector image
  logic ev_done, ev_tmo; // One-cycle events
  logic start; // Accepted control write
  logic [6:0] byte_idx; // Buffer index during loading
  logic loading; // Program byte-load phase
  logic [7:0] last_step;
  sfpic_req_t req;
  logic req_valid;
  logic st_done;
  logic [DATA_W-1:0] st_rdata;
  sfpic_pins_t pins;

  // ----------------------------------------
  // Strobe engine
  // ----------------------------------------
  sfpic_strobe u_strobe (
    .clk(CORE_CLK),
    .reset(RESET),
    .req_valid(req_valid),
    .req(req),
    .dq_in(FLASH_DQ_IN),
    .done(st_done),
    .rdata(st_rdata),
    .pins(pins)
  );

  assign FLASH_CE_N = pins.ce_n;
  assign FLASH_OE_N = pins.oe_n;
  assign FLASH_WE_N = pins.we_n;
  assign FLASH_ADDR = pins.addr;
  assign FLASH_DQ_OUT = pins.dq;
  assign FLASH_DQ_OE = pins.dq_oe;

  // ----------------------------------------
  // Request composition
  // ----------------------------------------
  assign start = REG_WR && (REG_ADDR == REG_CTRL) && (state_ff == SFH_IDLE);
  assign byte_idx = 7'(step_ff - 8'(UNLOCK_STEPS));
  assign loading = (state_ff == SFH_WR) && (op_ff == OP_PGM) && (step_ff >= 8'(UNLOCK_STEPS));
  assign last_step = (op_ff == OP_PGM) ? 8'(UNLOCK_STEPS + SECTOR_BYTES - 1) : 8'(UNLOCK_STEPS - 1);
  assign req_valid = !issued_ff && (state_ff == SFH_WR || state_ff == SFH_RD || state_ff == SFH_POLL);

  // Pick the address and data of the next bus cycle
  always_comb begin
    req = '{wr: 1'b1, addr: UNL_A0, data: UNL_D0};
    case (state_ff)
      SFH_WR: begin
        // Program and identification operations start with the unlock code; see R05
        if (step_ff == 8'h01) begin
          req.addr = UNL_A1;
          req.data = UNL_D1;
        end else if (step_ff == 8'h02) begin
          req.data = (op_ff == OP_PGM) ? CMD_PGM : (op_ff == OP_IDIN) ? CMD_IDIN : CMD_IDOUT; // see R11
        end else if (step_ff != 8'h00) begin
          // Sector in the upper field, byte in the lower; see R01
          req.addr = {sector_ff, byte_idx};
          req.data = buf_mem[byte_idx];
        end
      end
      SFH_RD: begin
        // Also reads identity codes when the mode is entered; see R09
        req = '{wr: 1'b0, addr: raddr_ff, data: 8'h00};
      end
      SFH_POLL: begin
        // Fixed address: first byte of the sector; see R08
        req = '{wr: 1'b0, addr: {sector_ff, 7'h00}, data: 8'h00};
      end
      default: begin
        req = '{wr: 1'b1, addr: UNL_A0, data: UNL_D0};
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_step = step_ff;
    nxt_issued = issued_ff;
    nxt_tmo = tmo_ff;
    nxt_tog_prev = tog_prev_ff;
    nxt_have_prev = have_prev_ff;
    nxt_poll_ok = poll_ok_ff;
    nxt_rdata_last = rdata_last_ff;
    ev_done = 1'b0;
    ev_tmo = 1'b0;
    if (req_valid) begin
      nxt_issued = 1'b1;
    end else if (st_done) begin
      nxt_issued = 1'b0;
    end
    case (state_ff)
      SFH_IDLE: begin
        if (start) begin
          nxt_op = sfpic_op_t'(REG_WDATA[1:0]);
          nxt_step = 8'h00;
          nxt_tmo = 20'h00000;
          nxt_have_prev = 1'b0;
          nxt_state = (REG_WDATA[1:0] == OP_READ) ? SFH_RD : SFH_WR;
        end
      end
      SFH_WR: begin
        if (st_done) begin
          nxt_step = step_ff + 8'h01;
          if (step_ff == last_step) begin
            // Full sector written back to back; see R02
            nxt_state = (op_ff == OP_PGM) ? SFH_GAP : SFH_IDLE;
            ev_done = (op_ff != OP_PGM);
          end
        end
      end
      SFH_RD: begin
        if (st_done) begin
          nxt_rdata_last = st_rdata;
          ev_done = 1'b1;
          nxt_state = SFH_IDLE;
        end
      end
      SFH_GAP: begin
        // Silence past the load gap starts the internal cycle; see R04
        nxt_tmo = tmo_ff + 20'h00001;
        if (tmo_ff == 20'(BLC_CYC - 1)) begin
          nxt_tmo = 20'h00000;
          nxt_state = SFH_POLL;
        end
      end
      SFH_POLL: begin
        if (tmo_ff != 20'hFFFFF) begin
          nxt_tmo = tmo_ff + 20'h00001;
        end
        if (st_done) begin
          nxt_rdata_last = st_rdata;
          nxt_tog_prev = st_rdata[TOG_BIT];
          nxt_have_prev = 1'b1;
          // Two equal toggle samples mean the cycle ended; see R07 R06
          if (have_prev_ff && (st_rdata[TOG_BIT] == tog_prev_ff)) begin
            nxt_poll_ok = (st_rdata[POLL_BIT] == buf_mem[SECTOR_BYTES-1][POLL_BIT]); // see R14
            ev_done = 1'b1;
            nxt_state = SFH_IDLE;
          end else if (tmo_ff >= 20'(TMO_CYC)) begin
            // Give up once the longest cycle time has passed; see R13
            ev_tmo = 1'b1;
            nxt_state = SFH_IDLE;
          end
        end
      end
      default: begin
        nxt_state = SFH_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Software registers and interrupt
  // ----------------------------------------
  always_comb begin
    nxt_sector = sector_ff;
    nxt_raddr = raddr_ff;
    nxt_irq_en = irq_en_ff;
    // Hardware set wins over a clear in the same cycle
    nxt_irq_stat = irq_stat_ff;
    if (REG_WR && REG_ADDR == REG_IRQ_CLR) begin
      nxt_irq_stat = irq_stat_ff & ~REG_WDATA[IRQ_W-1:0];
    end
    nxt_irq_stat[IRQ_DONE] = nxt_irq_stat[IRQ_DONE] | ev_done;
    nxt_irq_stat[IRQ_TMO] = nxt_irq_stat[IRQ_TMO] | ev_tmo;
    nxt_irq = |(nxt_irq_stat & nxt_irq_en);
    // Sector and address are frozen while an operation runs
    if (REG_WR && state_ff == SFH_IDLE && REG_ADDR == REG_SECTOR) begin
      nxt_sector = REG_WDATA[8:0];
    end
    if (REG_WR && state_ff == SFH_IDLE && REG_ADDR == REG_RADDR) begin
      nxt_raddr = REG_WDATA[ADDR_W-1:0];
    end
    if (REG_WR && REG_ADDR == REG_IRQ_EN) begin
      nxt_irq_en = REG_WDATA[IRQ_W-1:0];
    end
    nxt_rdata = 32'h00000000;
    if (REG_RD) begin
      case (REG_ADDR)
        REG_CTRL: nxt_rdata = {30'h00000000, op_ff};
        REG_SECTOR: nxt_rdata = {23'h000000, sector_ff};
        REG_RADDR: nxt_rdata = {16'h0000, raddr_ff};
        REG_STATUS: begin
          nxt_rdata[STAT_BUSY] = (state_ff != SFH_IDLE);
          nxt_rdata[STAT_POLL_OK] = poll_ok_ff;
          nxt_rdata[STAT_RDATA_LSB +: DATA_W] = rdata_last_ff;
        end
        REG_IRQ_STAT: nxt_rdata = {30'h00000000, irq_stat_ff};
        REG_IRQ_EN: nxt_rdata = {30'h00000000, irq_en_ff};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // Register all control state
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state_ff <= SFH_IDLE;
      op_ff <= OP_READ;
      step_ff <= 8'h00;
      issued_ff <= 1'b0;
      tmo_ff <= 20'h00000;
      tog_prev_ff <= 1'b0;
      have_prev_ff <= 1'b0;
      poll_ok_ff <= 1'b0;
      rdata_last_ff <= 8'h00;
      sector_ff <= 9'h000;
      raddr_ff <= 16'h0000;
      irq_stat_ff <= 2'h0;
      irq_en_ff <= 2'h0;
      irq_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      step_ff <= nxt_step;
      issued_ff <= nxt_issued;
      tmo_ff <= nxt_tmo;
      tog_prev_ff <= nxt_tog_prev;
      have_prev_ff <= nxt_have_prev;
      poll_ok_ff <= nxt_poll_ok;
      rdata_last_ff <= nxt_rdata_last;
      sector_ff <= nxt_sector;
      raddr_ff <= nxt_raddr;
      irq_stat_ff <= nxt_irq_stat;
      irq_en_ff <= nxt_irq_en;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  // Sector image: offsets 0x80..0xFF, write only; bytes not written
  // keep old contents and the flash still receives all of them
  always_ff @(posedge CORE_CLK) begin
    if (REG_WR && REG_ADDR[BUF_SEL_BIT]) begin
      buf_mem[REG_ADDR[6:0]] <= REG_WDATA[DATA_W-1:0]; // see R03
    end
  end

  assign REG_RDATA = rdata_ff;
  assign IRQ = irq_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [7:0] ld_cnt_ff; // Byte strobes in this program
  logic [11:0] gap_cnt_ff; // Cycles since last byte strobe
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ld_cnt_ff <= 8'h00;
      gap_cnt_ff <= 12'h000;
    end else begin
      // Count issued byte loads; the strobe pins are still idle when a load is offered
      ld_cnt_ff <= start ? 8'h00 : ld_cnt_ff + 8'((loading && req_valid) ? 1 : 0);
      gap_cnt_ff <= (!loading || req_valid) ? 12'h000 : gap_cnt_ff + 12'h001;
    end
  end

  sequence s_we_pulse;
    (!pins.we_n)[*5] ##1 pins.we_n;
  endsequence
  sequence s_poll_hit;
    (state_ff == SFH_POLL) && st_done && ev_done;
  endsequence

  property p_sector_on_load;
    @(posedge CORE_CLK) disable iff (RESET)
      (loading && $fell(pins.we_n)) |-> pins.addr[ADDR_W-1:SECT_LSB] == sector_ff;
  endproperty
  a_sector_on_load: assert property (p_sector_on_load) else $error("sector field wrong"); // see R01

  property p_full_sector;
    @(posedge CORE_CLK) disable iff (RESET)
      $rose(state_ff == SFH_GAP) |-> ld_cnt_ff == 8'(SECTOR_BYTES - 1) + 8'h01;
  endproperty
  a_full_sector: assert property (p_full_sector) else $error("sector not fully loaded"); // see R02

  property p_load_gap;
    @(posedge CORE_CLK) disable iff (RESET)
      loading |-> gap_cnt_ff < 12'(BLC_MAX_CYC);
  endproperty
  a_load_gap: assert property (p_load_gap) else $error("byte load gap too long"); // see R04

  property p_poll_agree;
    @(posedge CORE_CLK) disable iff (RESET)
      s_poll_hit |-> (have_prev_ff && st_rdata[TOG_BIT] == tog_prev_ff) ##1 (state_ff == SFH_IDLE);
  endproperty
  a_poll_agree: assert property (p_poll_agree) else $error("done without two agreeing reads"); // see R07

  property p_poll_addr;
    @(posedge CORE_CLK) disable iff (RESET)
      (!pins.ce_n && state_ff == SFH_POLL && $past(state_ff) == SFH_POLL) |-> pins.addr == {sector_ff, 7'h00};
  endproperty
  a_poll_addr: assert property (p_poll_addr) else $error("polling address moved"); // see R08

  property p_oe_high_on_write;
    @(posedge CORE_CLK) disable iff (RESET)
      (!pins.we_n && !pins.ce_n) |-> pins.oe_n && pins.dq_oe;
  endproperty
  a_oe_high_on_write: assert property (p_oe_high_on_write) else $error("output drive low in write"); // see R12

  property p_we_width;
    @(posedge CORE_CLK) disable iff (RESET)
      $fell(pins.we_n) |-> s_we_pulse;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse width wrong"); // width is WP_CYC cycles, from T_WP_NS
endmodule : sfpic_host
`default_nettype wire

// file: sim/sfpic_flash_model.sv
/*
  Behavioural flash device on the strobe pins, sampled on the core clock.
  Assumes the bench resolves the shared data wire; power_rst is power-up.
*/
`timescale 1ns/100ps
`default_nettype none
module sfpic_flash_model
  import sfpic_pkg::*;
#(
  parameter int BUSY_CYC = 2000, // Internal program time, shortened
  parameter int GAP_CYC = 3700, // Idle gap that ends the load phase
  parameter logic [7:0] MAKER_CODE = 8'hC4, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h6B // Arbitrary value
) (
  input wire logic clk,
  input wire logic power_rst,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] dq,
  input wire logic stuck, // Bench order: never finish programming
  output logic [7:0] dq_out,
  output var int errs // Host protocol breaches seen
);
  logic [7:0] mem [0:65535];
  logic [1:0] step;
  logic id_mode, loading, tog, wr_q, rd_q;
  logic [7:0] last, val, drv;
  logic [15:0] gap, paddr;
  logic [127:0] ld;
  logic [8:0] sec;
  int busy;
  // Erased array reads all ones, so identity and array reads differ
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
  wire logic rd_on = !ce_n && !oe_n && we_n;
  wire logic wr_end = !wr_q && (ce_n | we_n);
  // Released wire shows the inverse of the last byte, not a stale copy
  assign dq_out = rd_on ? val : ~drv;
  // Read value: status while busy, codes at addresses 0 and 1 in id mode, else the array
  always_comb begin
    if (busy > 0) val = {~last[POLL_BIT], tog, 6'h00};
    else if (id_mode && addr[15:1] == 15'h0) val = addr[0] ? PART_CODE : MAKER_CODE;
    else val = mem[addr];
  end
  // ----------------------------------------
  // Command, load and program sequencing
  // ----------------------------------------
  always @(posedge clk or posedge power_rst) begin
    if (power_rst) begin
      step <= 2'd0;
      id_mode <= 1'b0;
      loading <= 1'b0;
      busy <= 0;
      tog <= 1'b0;
      wr_q <= 1'b1;
      rd_q <= 1'b0;
      errs <= 0;
    end else begin
      wr_q <= ce_n | we_n;
      rd_q <= rd_on;
      if (rd_on) drv <= val;
      if (!we_n && !ce_n && !oe_n) errs <= errs + 1;
      if (busy > 0 && !stuck) busy <= busy - 1;
      if (rd_q && !rd_on && busy > 0) begin
        tog <= !tog;
        paddr <= addr;
        if (paddr != addr && busy < BUSY_CYC - 20) errs <= errs + 1;
      end
      if (loading) begin
        gap <= gap + 16'h1;
        if (wr_end) begin
          if (ld != '0 && addr[15:7] != sec) errs <= errs + 1;
          mem[addr] <= dq;
          last <= dq;
          sec <= addr[15:7];
          ld[addr[6:0]] <= 1'b1;
          gap <= 16'h0;
        end
        if (gap == 16'(GAP_CYC)) begin
          if (~&ld) errs <= errs + 1;
          for (int i = 0; i < 128; i++) if (!ld[i]) mem[{sec, 7'(i)}] <= 8'hXX;
          loading <= 1'b0;
          busy <= BUSY_CYC;
          step <= 2'd0;
        end
      end else if (wr_end && busy == 0) begin
        case (step)
          2'd0: step <= (addr == UNL_A0 && dq == UNL_D0) ? 2'd1 : 2'd0;
          2'd1: step <= (addr == UNL_A1 && dq == UNL_D1) ? 2'd2 : 2'd0;
          default: begin
            step <= 2'd0;
            if (addr == UNL_A0 && dq == CMD_PGM) begin
              loading <= 1'b1;
              ld <= '0;
              gap <= 16'h0;
            end
            if (addr == UNL_A0 && dq == CMD_IDIN) id_mode <= 1'b1;
            if (addr == UNL_A0 && dq == CMD_IDOUT) id_mode <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule : sfpic_flash_model
`default_nettype wire

// file: sim/tb_top.sv
/*
  Register-port testbench of the flash host controller.
  Assumes the flash model on the pins and a shortened polling timeout.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import sfpic_pkg::*;
;
  localparam logic [7:0] MAKER = 8'hC4; // Arbitrary value
  localparam logic [7:0] PART = 8'h6B; // Arbitrary value
  logic CORE_CLK = 1'b0, RESET = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, stuck = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0, rd_data;
  wire logic [31:0] REG_RDATA;
  wire logic IRQ, ce_n, oe_n, we_n, dq_oe;
  wire logic [15:0] fa;
  wire logic [7:0] dq_o, dq_m;
  wire logic [7:0] dq_i = dq_oe ? dq_o : dq_m; // Host drive wins the wire
  int bad_count = 0, compares = 0, errs;
  always #20 CORE_CLK = ~CORE_CLK;
  sfpic_host #(.TMO_CYC(20000)) u_dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ),
    .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n), .FLASH_WE_N(we_n), .FLASH_ADDR(fa),
    .FLASH_DQ_OUT(dq_o), .FLASH_DQ_OE(dq_oe), .FLASH_DQ_IN(dq_i));
  sfpic_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (.clk(CORE_CLK),
    .power_rst(RESET), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .dq(dq_o),
    .stuck(stuck), .dq_out(dq_m), .errs(errs));
  // ----------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1 rd_data = REG_RDATA;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Start an operation and poll busy with a bounded count
  task automatic run_op(input logic [31:0] op);
    wr(REG_CTRL, op);
    repeat (4) @(posedge CORE_CLK);
    rd(REG_STATUS);
    for (int i = 0; i < 5000 && rd_data[STAT_BUSY] !== 1'b0; i++) rd(REG_STATUS);
    chk(rd_data & 32'h1, 32'h0);
  endtask : run_op
  task automatic rd_flash(input logic [15:0] a, input logic [7:0] exp);
    wr(REG_RADDR, {16'h0, a});
    run_op(OP_READ);
    rd(REG_STATUS);
    chk({24'h0, rd_data[15:8]}, {24'h0, exp});
  endtask : rd_flash
  task automatic complete_run;
    $display("Counts: compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // Test sequence and watchdog
  // ----------------------------------------
  initial begin
    #3200000;
    bad_count++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge CORE_CLK);
    RESET <= 1'b0;
    rd(REG_STATUS);
    chk(rd_data, 32'h0);
    rd(8'h40);
    chk(rd_data, 32'h0);
    wr(REG_IRQ_EN, 32'h3);
    $display("Test reset values done");
    wr(REG_SECTOR, 32'h5);
    for (int i = 0; i < SECTOR_BYTES; i++) wr(8'h80 + 8'(i), {24'h0, 8'(i) ^ 8'h3C});
    wr(REG_CTRL, OP_PGM);
    wr(REG_SECTOR, 32'h7);
    run_op(OP_PGM);
    rd(REG_SECTOR);
    chk(rd_data, 32'h5);
    chk({31'h0, IRQ}, 32'h1);
    rd(REG_STATUS);
    chk(rd_data, 32'h00003C02);
    wr(REG_IRQ_CLR, 32'h1);
    rd(REG_IRQ_STAT);
    chk(rd_data, 32'h0);
    for (int i = 0; i < 128; i += 63) rd_flash(16'h0280 + 16'(i), 8'(i) ^ 8'h3C);
    $display("Test program done");
    run_op(OP_IDIN);
    rd_flash(16'h0000, MAKER);
    rd_flash(16'h0001, PART);
    RESET <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    RESET <= 1'b0;
    rd_flash(16'h0000, 8'hFF);
    run_op(OP_IDIN);
    run_op(OP_IDOUT);
    chk({31'h0, IRQ}, 32'h0);
    rd(REG_IRQ_STAT);
    chk(rd_data, 32'h1);
    rd_flash(16'h0000, 8'hFF);
    $display("Test identification done");
    wr(REG_IRQ_EN, 32'h2);
    wr(REG_SECTOR, 32'h6);
    stuck <= 1'b1;
    wr(REG_CTRL, OP_PGM);
    for (int i = 0; i < 30000 && IRQ !== 1'b1; i++) @(posedge CORE_CLK);
    rd(REG_IRQ_STAT);
    chk(rd_data & 32'h2, 32'h2);
    chk(32'(errs), 32'h0);
    $display("Test timeout done");
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
